/* fwr_event_report.sv */
// Fault and warning event reporter with its I2C target port
module fwr_event_report import fwr_pkg::*; #(
  parameter int STRAP_CYCLES = STRAP_WAIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire fwr_evt_t evt_in,
  input wire fwr_ctl_t ctl,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic fault_in,
  output logic fault_out,
  output logic fault_oe,
  output logic [NCH-1:0] shutdown,
  output logic [NCH-1:0] auto_recovery,
  output logic foldback_drive,
  output logic addr_sel
);

  localparam int STRAP_W = $clog2(STRAP_CYCLES + 1);

  if (STRAP_CYCLES < 1) begin : g_check
    $error("STRAP_CYCLES must be at least 1");
  end

  // Memory bit: hold, clear on read, a new event wins over the clear
  function automatic logic [7:0] latch8(
    input logic [7:0] mem,
    input logic clr,
    input logic [7:0] evt
  );
    return (mem & ~{8{clr}}) | evt;
  endfunction

  // ---------------- System clock domain ----------------

  fwr_evt_t evt;
  logic fault_s;
  logic req_s;
  logic req_d;
  logic ack_tgl;
  logic [7:0] rd_data;
  logic [NCH-1:0] hard_sd;
  logic [NCH-1:0] next_hard_sd;
  logic [STRAP_W-1:0] strap_cnt;
  logic strap_done;

  logic [7:0] ts_mem;
  logic [7:0] ocdc_mem;
  logic [7:0] lf_mem;
  logic [7:0] wr_mem;
  logic [7:0] lw_mem;
  logic [7:0] clip_mem;

  // Link-side registers read across the handshake
  logic req_tgl;
  logic [7:0] ptr;

  fwr_sync #(.W($bits(fwr_evt_t))) u_evt_sync (
    .clk(clk),
    .nrst(nrst),
    .d(evt_in),
    .q(evt)
  );

  fwr_sync #(.W(1)) u_fault_sync (
    .clk(clk),
    .nrst(nrst),
    .d(fault_in),
    .q(fault_s)
  );

  fwr_sync #(.W(1)) u_req_sync (
    .clk(clk),
    .nrst(nrst),
    .d(req_tgl),
    .q(req_s)
  );

  // Live conditions
  wire [NCH-1:0] over_temp_shutdown_any = evt.over_temp_shutdown_ch | {NCH{evt.over_temp_shutdown_glb}};
  wire [NCH-1:0] oc_evt = evt.over_current | evt.load_fault;
  wire clk_fault = ctl.clock_follower & evt.clk_invalid;
  wire fb_warn = ctl.foldback_enable & evt.gain_reduced;
  wire otw_any = (|evt.otw_ch) | evt.otw_glb;

  // Shutdown that waits for an explicit clear
  wire [NCH-1:0] over_temp_shutdown_hold = over_temp_shutdown_any & {NCH{~ctl.over_temp_shutdown_auto_recovery}};
  wire [NCH-1:0] hard_set =
    oc_evt | evt.dc_fault | over_temp_shutdown_hold;
  // Shutdown that lasts only as long as its cause
  wire [NCH-1:0] over_temp_shutdown_soft = over_temp_shutdown_any & {NCH{ctl.over_temp_shutdown_auto_recovery}};
  wire [NCH-1:0] soft_sd = over_temp_shutdown_soft | {NCH{clk_fault}};

  assign next_hard_sd = hard_set | (hard_sd & ~{NCH{ctl.fault_clear}});

  // Live register images
  fwr_ts_t ts_live;
  fwr_ocdc_t ocdc_evt;
  fwr_wr_t wr_live;
  fwr_chb_t lf_evt;
  fwr_chb_t lw_evt;
  fwr_chb_t clip_live;
  fwr_state_t ch_state;

  assign ts_live = '{rsvd: '0, clk_invalid: clk_fault,
                     over_temp_shutdown_glb: evt.over_temp_shutdown_glb,
                     over_temp_shutdown_ch: evt.over_temp_shutdown_ch};
  assign ocdc_evt = '{dc_fault: evt.dc_fault,
                      over_current: oc_evt};
  assign lf_evt = '{rsvd: '0, ch: evt.load_fault};
  assign wr_live = '{rsvd: '0, foldback: fb_warn, otw_glb: evt.otw_glb,
                     otw_ch: evt.otw_ch};
  assign lw_evt = '{rsvd: '0, ch: evt.load_warn};
  assign clip_live = '{rsvd: '0, ch: evt.clip};
  assign ch_state = '{auto_recovery: auto_recovery, shutdown: shutdown};

  // Read requests from the link; ptr is stable while a request is open
  wire rd_fire = req_s ^ req_d;
  wire clr_ts = rd_fire & (ptr == REG_TS_MEM);
  wire clr_ocdc = rd_fire & (ptr == REG_OCDC_MEM);
  wire clr_lf = rd_fire & (ptr == REG_LF_MEM);
  wire clr_wr = rd_fire & (ptr == REG_WR_MEM);
  wire clr_lw = rd_fire & (ptr == REG_LW_MEM);
  wire clr_clip = rd_fire & (ptr == REG_CLIP_MEM);

  // Register selection; unmapped pointers read zero
  // A plain mux keeps every source register in the sensitivity
  wire [7:0] sel_data =
    (ptr == REG_TS_STATUS) ? ts_live :
    (ptr == REG_TS_MEM) ? ts_mem :
    (ptr == REG_OCDC_MEM) ? ocdc_mem :
    (ptr == REG_LF_MEM) ? lf_mem :
    (ptr == REG_WR_STATUS) ? wr_live :
    (ptr == REG_WR_MEM) ? wr_mem :
    (ptr == REG_LW_MEM) ? lw_mem :
    (ptr == REG_CLIP_STATUS) ? clip_live :
    (ptr == REG_CLIP_MEM) ? clip_mem :
    (ptr == REG_CH_STATE) ? ch_state :
    MEM_RESET;
  wire strap_last = strap_cnt == STRAP_W'(STRAP_CYCLES - 1);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hard_sd <= '0;
      shutdown <= '0;
      auto_recovery <= '0;
      foldback_drive <= 1'b0;
    end else begin
      hard_sd <= next_hard_sd;
      shutdown <= next_hard_sd | soft_sd;
      auto_recovery <= soft_sd & ~next_hard_sd;
      foldback_drive <= ctl.foldback_enable & otw_any;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ts_mem <= MEM_RESET;
      ocdc_mem <= MEM_RESET;
      lf_mem <= MEM_RESET;
      wr_mem <= MEM_RESET;
      lw_mem <= MEM_RESET;
      clip_mem <= MEM_RESET;
    end else begin
      ts_mem <= latch8(ts_mem, clr_ts, ts_live);
      ocdc_mem <= latch8(ocdc_mem, clr_ocdc, ocdc_evt);
      lf_mem <= latch8(lf_mem, clr_lf, lf_evt);
      wr_mem <= latch8(wr_mem, clr_wr, wr_live);
      lw_mem <= latch8(lw_mem, clr_lw, lw_evt);
      clip_mem <= latch8(clip_mem, clr_clip, clip_live);
    end
  end

  // Read side of the handshake: data is frozen in the same cycle the ack toggles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_d <= 1'b0;
      ack_tgl <= 1'b0;
      rd_data <= MEM_RESET;
    end else begin
      req_d <= req_s;
      ack_tgl <= ack_tgl ^ rd_fire;
      if (rd_fire) begin
        rd_data <= sel_data;
      end
    end
  end

  // Strap: fault pin undriven until its level is taken after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strap_cnt <= '0;
      strap_done <= 1'b0;
      addr_sel <= 1'b0;
    end else if (!strap_done) begin
      if (strap_last) begin
        strap_done <= 1'b1;
        addr_sel <= fault_s;
      end else begin
        strap_cnt <= strap_cnt + STRAP_W'(1);
      end
    end
  end

  // Open-drain fault pin pulls low while any channel is shut down
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fault_oe <= 1'b0;
    end else begin
      fault_oe <= strap_done & (|(next_hard_sd | soft_sd));
    end
  end

  assign fault_out = 1'b0;

  // ---------------- Link clock domain ----------------

  logic [3:0] lnk_s;
  logic ack_s;
  logic ack_d;
  logic scl_d;
  logic sda_d;
  fwr_i2c_st_t st;
  fwr_i2c_st_t next_st;
  fwr_kind_t kind;
  fwr_kind_t next_kind;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [7:0] next_ptr;
  logic go_tx;
  logic next_go_tx;
  logic next_req;
  logic next_sda_oe;

  fwr_sync #(.W(4)) u_lnk_sync (
    .clk(link_clk),
    .nrst(nrst),
    .d({scl_in, sda_in, strap_done, addr_sel}),
    .q(lnk_s)
  );

  fwr_sync #(.W(1)) u_ack_sync (
    .clk(link_clk),
    .nrst(nrst),
    .d(ack_tgl),
    .q(ack_s)
  );

  wire scl = lnk_s[3];
  wire sda = lnk_s[2];
  wire lnk_ready = lnk_s[1];
  wire lnk_sel = lnk_s[0];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire bus_start = scl & scl_d & sda_d & ~sda;
  wire bus_stop = scl & scl_d & ~sda_d & sda;
  wire rd_done = ack_s ^ ack_d;

  // Read address from the strap; write address is one below it
  wire [7:0] rd_addr8 = lnk_sel ? I2C_RD_PULL : I2C_RD_FLOAT;
  wire [6:0] my_addr = rd_addr8[7:1];
  wire addr_hit = (sh[7:1] == my_addr) & lnk_ready;
  wire byte_end = scl_fall & (cnt == BYTE_BITS);
  wire tx_last = cnt == (BYTE_BITS - 4'h1);

  // Target only: SCL is never driven and no wait states are inserted
  always_comb begin
    next_st = st;
    next_kind = kind;
    next_cnt = cnt;
    next_sh = sh;
    next_ptr = ptr;
    next_go_tx = go_tx;
    next_req = req_tgl;
    unique case (st)
      ST_IDLE: begin
        next_cnt = '0;
      end
      ST_RX: begin
        if (scl_rise) begin
          next_sh = {sh[6:0], sda};
          next_cnt = cnt + 4'h1;
        end else if (byte_end) begin
          next_cnt = '0;
          next_st = ST_ACK;
          next_go_tx = 1'b0;
          case (kind)
            K_ADDR: begin
              if (!addr_hit) begin
                next_st = ST_IDLE;
              end else if (sh[0]) begin
                next_go_tx = 1'b1;
              end else begin
                next_kind = K_PTR;
              end
            end
            K_PTR: begin
              next_ptr = sh;
              next_kind = K_DATA;
            end
            default: begin
              next_ptr = ptr + 8'h01;
            end
          endcase
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          if (go_tx) begin
            next_req = ~req_tgl;
            next_st = ST_FETCH;
          end else begin
            next_st = ST_RX;
          end
        end
      end
      ST_FETCH: begin
        if (rd_done) begin
          next_sh = rd_data;
          next_ptr = ptr + 8'h01;
          next_cnt = '0;
          next_st = ST_TX;
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          next_sh = {sh[6:0], 1'b0};
          next_cnt = cnt + 4'h1;
          if (tx_last) begin
            next_cnt = '0;
            next_st = ST_MACK;
          end
        end
      end
      ST_MACK: begin
        if (scl_rise) begin
          next_go_tx = ~sda;
        end else if (scl_fall) begin
          if (go_tx) begin
            next_req = ~req_tgl;
            next_st = ST_FETCH;
          end else begin
            next_st = ST_IDLE;
          end
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
    if (bus_start) begin
      next_st = ST_RX;
      next_kind = K_ADDR;
      next_cnt = '0;
    end else if (bus_stop) begin
      next_st = ST_IDLE;
    end
    next_sda_oe = (next_st == ST_ACK) |
                  ((next_st == ST_TX) & ~next_sh[7]);
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      ack_d <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      ack_d <= ack_s;
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      st <= ST_IDLE;
      kind <= K_ADDR;
      cnt <= '0;
      sh <= '0;
      ptr <= '0;
      go_tx <= 1'b0;
      req_tgl <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      cnt <= next_cnt;
      sh <= next_sh;
      ptr <= next_ptr;
      go_tx <= next_go_tx;
      req_tgl <= next_req;
      sda_oe <= next_sda_oe;
    end
  end

  assign sda_out = 1'b0;

endmodule

/* fwr_pkg.sv */
// Constants and types of the fault and warning event reporter
// How it works
// - Over-temp, no auto recovery: latched shutdown until cleared
// - Auto-recovery bit: shutdown follows over-temp, self-recovers
// - Over-temp live in status, latched in memory
// - Over-current: memory only, channel shutdown
// - Load-current fault also raises over-current
// - DC fault: memory only, channel shutdown
// - Load-current fault latched in its memory only
// - Follower mode: invalid clock forces auto-recovering shutdown
// - Valid clock again clears fault automatically
// - Follower mode: invalid clock live in status, latched in memory
// - Over-temp warnings live and latched
// - Foldback enabled: warnings drive gain reduction
// - Foldback warning while enabled gain below 0 dB
// - Load-current warning latched only, no status
// - Clip warnings live and latched per channel
// - I2C target only; controller polls
// - Fault pin pull-up at power-up picks address
// - Reading memory clears it, not status
package fwr_pkg;

  localparam int NCH = 4;

  // 8-bit bus addresses, address byte including direction bit
  localparam logic [7:0] I2C_RD_FLOAT = 8'h59;
  localparam logic [7:0] I2C_WR_PULL = 8'h5a;
  localparam logic [7:0] I2C_RD_PULL = 8'h5b;

  // Register pointers
  localparam logic [7:0] REG_TS_STATUS = 8'h00;
  localparam logic [7:0] REG_TS_MEM = 8'h01;
  localparam logic [7:0] REG_OCDC_MEM = 8'h02;
  localparam logic [7:0] REG_LF_MEM = 8'h03;
  localparam logic [7:0] REG_WR_STATUS = 8'h04;
  localparam logic [7:0] REG_WR_MEM = 8'h05;
  localparam logic [7:0] REG_LW_MEM = 8'h06;
  localparam logic [7:0] REG_CLIP_STATUS = 8'h07;
  localparam logic [7:0] REG_CLIP_MEM = 8'h08;
  localparam logic [7:0] REG_CH_STATE = 8'h09;
  localparam logic [7:0] MEM_RESET = 8'h00;

  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Wait after reset before the fault pin level is taken as strap
  localparam int CLK_MHZ = 125;
  localparam int STRAP_WAIT_NS = 1000;
  localparam int STRAP_WAIT_CYC = (STRAP_WAIT_NS * CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic [NCH-1:0] over_temp_shutdown_ch;
    logic over_temp_shutdown_glb;
    logic [NCH-1:0] over_current;
    logic [NCH-1:0] dc_fault;
    logic [NCH-1:0] load_fault;
    logic clk_invalid;
    logic [NCH-1:0] otw_ch;
    logic otw_glb;
    logic gain_reduced;
    logic [NCH-1:0] load_warn;
    logic [NCH-1:0] clip;
  } fwr_evt_t;

  typedef struct packed {
    logic over_temp_shutdown_auto_recovery;
    logic foldback_enable;
    logic clock_follower;
    logic fault_clear;
  } fwr_ctl_t;

  // Register byte layouts
  typedef struct packed {
    logic [1:0] rsvd;
    logic clk_invalid;
    logic over_temp_shutdown_glb;
    logic [NCH-1:0] over_temp_shutdown_ch;
  } fwr_ts_t;

  typedef struct packed {
    logic [NCH-1:0] dc_fault;
    logic [NCH-1:0] over_current;
  } fwr_ocdc_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic foldback;
    logic otw_glb;
    logic [NCH-1:0] otw_ch;
  } fwr_wr_t;

  typedef struct packed {
    logic [NCH-1:0] rsvd;
    logic [NCH-1:0] ch;
  } fwr_chb_t;

  typedef struct packed {
    logic [NCH-1:0] auto_recovery;
    logic [NCH-1:0] shutdown;
  } fwr_state_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_FETCH = 3'b011,
    ST_TX = 3'b100,
    ST_MACK = 3'b101
  } fwr_i2c_st_t;

  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_PTR = 2'b01,
    K_DATA = 2'b10
  } fwr_kind_t;

endpackage

/* fwr_sync.sv */
// Two-stage level synchroniser
module fwr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  if (W < 1) begin : g_check
    $error("fwr_sync needs W of at least 1");
  end

  // The first stage feeds only the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

/* fwr_checker.sv */
// Port-level assertions for the fault and warning event reporter
module fwr_checker import fwr_pkg::*; #(
  parameter int STRAP_CYCLES = STRAP_WAIT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire fwr_evt_t evt_in,
  input wire fwr_ctl_t ctl,
  input wire logic fault_oe,
  input wire logic [NCH-1:0] shutdown,
  input wire logic [NCH-1:0] auto_recovery,
  input wire logic foldback_drive,
  input wire logic addr_sel
);
  logic [7:0] cnt;
  logic warn;
  assign warn = (|evt_in.otw_ch) || evt_in.otw_glb;
  // Saturates so the strap window never wraps round on long runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt <= 8'h00;
    else if (cnt != 8'hff) cnt <= cnt + 8'h01;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Events need three samples through the synchroniser
  sequence s_ick;
    (ctl.clock_follower && evt_in.clk_invalid) [*3];
  endsequence
  sequence s_warn;
    (ctl.foldback_enable && warn) [*3];
  endsequence
  property p_oc;
    evt_in.over_current[0] [*2] |-> ##[1:3] shutdown[0];
  endproperty
  a_oc: assert property (p_oc) else $error("oc shutdown missing");
  property p_lf;
    evt_in.load_fault[1] [*2] |-> ##[1:3] shutdown[1];
  endproperty
  a_lf: assert property (p_lf) else $error("lf shutdown missing");
  property p_dc;
    evt_in.dc_fault[2] [*2] |-> ##[1:3] shutdown[2];
  endproperty
  a_dc: assert property (p_dc) else $error("dc shutdown missing");
  // Latched shutdown may only end after a clear request
  property p_hard;
    !ctl.fault_clear && !$past(ctl.fault_clear) |=>
      ($past(shutdown) & ~$past(auto_recovery) & ~shutdown) == 4'h0;
  endproperty
  a_hard: assert property (p_hard) else $error("hard release");
  property p_ick;
    s_ick |=> (&shutdown);
  endproperty
  a_ick: assert property (p_ick) else $error("ick no shutdown");
  property p_fold_on;
    s_warn |=> foldback_drive;
  endproperty
  a_fold_on: assert property (p_fold_on) else $error("fold off");
  property p_fold_off;
    (!ctl.foldback_enable) [*2] |=> !foldback_drive;
  endproperty
  a_fold_off: assert property (p_fold_off) else $error("fold on");
  property p_strap;
    cnt < STRAP_CYCLES |-> !fault_oe;
  endproperty
  a_strap: assert property (p_strap) else $error("early fault");
  property p_addr;
    cnt > STRAP_CYCLES + 1 |-> $stable(addr_sel);
  endproperty
  a_addr: assert property (p_addr) else $error("addr moved");
endmodule

bind fwr_event_report fwr_checker #(.STRAP_CYCLES(STRAP_CYCLES))
  fwr_checker_inst (.clk(clk), .nrst(nrst), .evt_in(evt_in), .ctl(ctl),
  .fault_oe(fault_oe), .shutdown(shutdown), .auto_recovery(auto_recovery),
  .foldback_drive(foldback_drive), .addr_sel(addr_sel));

/* fwr_i2c_master.sv */
// Behavioural I2C controller that polls the reporter
module fwr_i2c_master (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Long low phase: target has no clock stretching
  localparam int Q = 300;
  logic [7:0] got [0:7];
  logic nack;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    nack = 1'b0;
  end
  // Data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start;
    sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop;
    sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nack = 1'b1;
  endtask
  // Pointer write, repeated start, reads; ACK continues, NACK ends
  task automatic rd(input logic [7:0] a, input logic [7:0] p, input int n);
    logic r;
    nack = 1'b0;
    start;
    wbyte(a - 8'h01);
    wbyte(p);
    start;
    wbyte(a);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(1'b1, r);
        got[k][i] = r;
      end
      bit_io(k == n - 1, r);
    end
    stop;
  endtask
endmodule

/* fwr_event_report_tb_top.sv */
// Self-checking bench for the fault and warning event reporter
module fwr_event_report_tb_top
  import fwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 4;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst, scl, sda_m, sda, sda_out, sda_oe, strap_pu;
  logic fault_in, fault_out, fault_oe, foldback_drive, addr_sel;
  logic [NCH-1:0] shutdown, auto_recovery;
  fwr_evt_t evt_in;
  fwr_ctl_t ctl;
  logic [7:0] exp [$];
  int n_fail = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  initial begin
    #11;
    forever #16 link_clk = ~link_clk;
  end
  // Open-drain lines: low wins, pull-ups elsewhere
  assign sda = sda_m & ~(sda_oe & ~sda_out);
  assign fault_in = strap_pu & ~(fault_oe & ~fault_out);
  fwr_event_report #(.STRAP_CYCLES(SC)) fwr_event_report_inst (
    .clk(clk), .nrst(nrst), .link_clk(link_clk), .evt_in(evt_in),
    .ctl(ctl), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .fault_in(fault_in), .fault_out(fault_out),
    .fault_oe(fault_oe), .shutdown(shutdown),
    .auto_recovery(auto_recovery), .foldback_drive(foldback_drive),
    .addr_sel(addr_sel));
  fwr_i2c_master fwr_i2c_master_inst (.scl(scl), .sda_m(sda_m), .sda(sda));
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reset_dut(input logic pu);
    strap_pu = pu;
    evt_in = '0;
    ctl = '0;
    nrst = 1'b0;
    cyc(4);
    nrst = 1'b1;
    cyc(SC + 16);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] p,
                        input logic nk);
    fwr_i2c_master_inst.rd(a, p, exp.size());
    chk("nack", {7'h0, nk}, {7'h0, fwr_i2c_master_inst.nack});
    for (int k = 0; k < exp.size(); k++)
      chk("register", exp[k], fwr_i2c_master_inst.got[k]);
    cyc(1);
  endtask
  task automatic clear_faults;
    ctl.fault_clear = 1'b1;
    cyc(3);
    ctl.fault_clear = 1'b0;
    cyc(3);
  endtask
  initial begin
    // Budget assumes about 47 bus bytes at 1.2 us a bit
    #800000;
    n_fail++;
    complete_run;
  end
  initial begin
    reset_dut(1'b0);
    chk("addr_sel", 8'h00, {7'h0, addr_sel});
    exp = {};
    rd_chk(I2C_RD_PULL, REG_CH_STATE, 1'b1);
    evt_in.over_current[0] = 1'b1;
    evt_in.load_fault[1] = 1'b1;
    evt_in.dc_fault[2] = 1'b1;
    cyc(3);
    evt_in = '0;
    cyc(6);
    chk("shutdown", 8'h07, {4'h0, shutdown});
    chk("fault_oe", 8'h01, {7'h0, fault_oe});
    exp = '{8'h43, 8'h02};
    rd_chk(I2C_RD_FLOAT, REG_OCDC_MEM, 1'b0);
    exp = '{8'h00, 8'h00};
    rd_chk(I2C_RD_FLOAT, REG_OCDC_MEM, 1'b0);
    chk("held", 8'h07, {auto_recovery, shutdown});
    clear_faults;
    evt_in.over_temp_shutdown_ch[3] = 1'b1;
    cyc(6);
    evt_in.over_temp_shutdown_ch[3] = 1'b0;
    cyc(6);
    chk("over_temp_shutdown hard", 8'h08, {auto_recovery, shutdown});
    clear_faults;
    chk("cleared", 8'h00, {auto_recovery, shutdown});
    chk("fault_oe off", 8'h00, {7'h0, fault_oe});
    ctl.over_temp_shutdown_auto_recovery = 1'b1;
    evt_in.over_temp_shutdown_ch[3] = 1'b1;
    evt_in.over_temp_shutdown_glb = 1'b1;
    cyc(6);
    chk("over_temp_shutdown soft", 8'hff, {auto_recovery, shutdown});
    exp = '{8'h18, 8'h18};
    rd_chk(I2C_RD_FLOAT, REG_TS_STATUS, 1'b0);
    evt_in.over_temp_shutdown_ch[3] = 1'b0;
    evt_in.over_temp_shutdown_glb = 1'b0;
    cyc(6);
    chk("over_temp_shutdown gone", 8'h00, {auto_recovery, shutdown});
    evt_in.clk_invalid = 1'b1;
    cyc(6);
    chk("no follower", 8'h00, {auto_recovery, shutdown});
    ctl.clock_follower = 1'b1;
    cyc(6);
    chk("ick", 8'hff, {auto_recovery, shutdown});
    exp = '{8'h20, 8'h38};
    rd_chk(I2C_RD_FLOAT, REG_TS_STATUS, 1'b0);
    evt_in.clk_invalid = 1'b0;
    cyc(6);
    chk("ick gone", 8'h00, {auto_recovery, shutdown});
    ctl.foldback_enable = 1'b1;
    evt_in.otw_ch[0] = 1'b1;
    evt_in.otw_glb = 1'b1;
    evt_in.gain_reduced = 1'b1;
    evt_in.clip[1] = 1'b1;
    evt_in.load_warn[2] = 1'b1;
    cyc(3);
    evt_in.load_warn[2] = 1'b0;
    cyc(4);
    chk("fold", 8'h01, {7'h0, foldback_drive});
    exp = '{8'h31, 8'h31, 8'h04, 8'h02, 8'h02};
    rd_chk(I2C_RD_FLOAT, REG_WR_STATUS, 1'b0);
    ctl.foldback_enable = 1'b0;
    cyc(4);
    chk("fold off", 8'h00, {7'h0, foldback_drive});
    evt_in = '0;
    cyc(4);
    exp = '{8'h00, 8'h31, 8'h00, 8'h00, 8'h02};
    rd_chk(I2C_RD_FLOAT, REG_WR_STATUS, 1'b0);
    reset_dut(1'b1);
    chk("addr_sel pu", 8'h01, {7'h0, addr_sel});
    exp = '{8'h00, 8'h00};
    rd_chk(I2C_RD_PULL, REG_CH_STATE, 1'b0);
    exp = {};
    rd_chk(I2C_RD_FLOAT, REG_CH_STATE, 1'b1);
    complete_run;
  end
endmodule
